// ### core/firing_event_select_seq_map.svh
// Functional notes
// [RULE_01] a reading starts only after arming, then firing, then a sample event
// [RULE_02] power-on selects automatic source on all three levels
// [RULE_03] arming event arms; only an armed sequencer accepts a firing event
// [RULE_04] firing after arming enables sampling; earlier sample events are ignored
// [RULE_05] one reading per sample event until the reading count is reached
// [RULE_06] reading count command carries count and sample source
// [RULE_07] automatic source fires at once whenever its level waits, at all levels
// [RULE_08] external source fires on each falling edge of the trigger input
// [RULE_09] level source only for firing and sample levels, on comparator hit
// [RULE_10] level source refused unless dc voltage or direct digitizing
// [RULE_11] power-line source only for firing and sample levels, at zero crossing
// [RULE_12] one-shot for arming and firing, occurs once then becomes suspend
// [RULE_13] suspend, for arming and firing, never occurs
// [RULE_14] host-pull occurs when output buffer and memory empty and host requests
// [RULE_15] interval timer only as sample source, spacing reading starts
// [RULE_16] timer and power-line refused for sync/random ac, frequency, period
// [RULE_17] all default states set reading count 1 and sample source automatic
// [RULE_18] standard default uses host-pull as firing source
// [RULE_19] choosing automatic on a suspended level resumes readings
// [RULE_20] command buffer off: bus held after one-shot until its readings end
// [RULE_21] command buffer on: queue commands, release bus, run them in order
// [RULE_22] after the count completes, return to waiting for arming
`ifndef FIRING_EVENT_SELECT_SEQ_MAP_SVH
`define FIRING_EVENT_SELECT_SEQ_MAP_SVH

`define RDG_CNT_W 16
`define RDG_CNT_RESET 16'h0001
`define TMR_W 32
`define CMDQ_DEPTH_DEF 4
`define LVL_ARM 2'h0
`define LVL_FIRE 2'h1
`define LVL_SMP 2'h2

`endif

// ### core/firing_event_select_seq_pkg.sv
package firing_event_select_seq_pkg;

	typedef enum logic [2:0] {
		SRC_AUTO, SRC_EXT, SRC_HOLD, SRC_LEVEL, SRC_LINE, SRC_SGL, SRC_SYN, SRC_TIMER
	} src_t;

	typedef enum logic [2:0] {
		CMD_ARM_SRC, CMD_FIRE_SRC, CMD_READ_COUNT, CMD_PRESET_STD, CMD_DIGITIZING_DEFAULT_STATE, CMD_RESET
	} cmd_t;

	typedef enum logic [3:0] {
		FN_DCV, FN_DIG_DIRECT, FN_ACV_SYNC, FN_ACV_RNDM, FN_ACDCV_SYNC, FN_ACDCV_RNDM,
		FN_FREQ, FN_PER, FN_OTHER
	} func_t;

	typedef enum logic [1:0] {
		ST_ARM, ST_FIRE, ST_SMP, ST_READ
	} seq_st_t;

	typedef struct packed {
		cmd_t code;
		src_t src;
		logic [15:0] count;
	} cmd_ent_t;

endpackage : firing_event_select_seq_pkg

// ### core/measurement_trigger_sequencer.sv
`timescale 1ns/1ns
`include "firing_event_select_seq_map.svh"

module measurement_trigger_sequencer #(
	parameter int QDEPTH = `CMDQ_DEPTH_DEF
) (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	// host command port
	input wire logic i_cmd_valid,
	input wire firing_event_select_seq_pkg::cmd_t i_cmd_code,
	input wire firing_event_select_seq_pkg::src_t i_cmd_src,
	input wire logic [`RDG_CNT_W-1:0] i_cmd_count,
	input wire logic i_input_command_buffer_en,
	// host data path status
	input wire logic i_host_req,
	input wire logic i_outbuf_empty,
	input wire logic i_mem_empty,
	// event sources
	input wire logic i_ext_firing_event_select_n,
	input wire logic i_level_hit,
	input wire logic i_line_zero,
	input wire logic [`TMR_W-1:0] i_timer_cycles,
	// front end
	input wire firing_event_select_seq_pkg::func_t i_func,
	input wire logic i_reading_done,
	// host side status
	output logic o_cmd_ready,
	output logic o_cmd_error,
	// sequencer status
	output logic o_reading_start,
	output logic o_armed,
	output logic o_fired,
	output logic o_group_done,
	output firing_event_select_seq_pkg::src_t o_arm_src,
	output firing_event_select_seq_pkg::src_t o_fire_src,
	output firing_event_select_seq_pkg::src_t o_smp_src,
	output logic [`RDG_CNT_W-1:0] o_rdg_count
);

	localparam int PW = (QDEPTH > 1) ? $clog2(QDEPTH) : 1;
	localparam int QW = $clog2(QDEPTH + 1);
	localparam int CW = `RDG_CNT_W;

	typedef struct packed {
		firing_event_select_seq_pkg::seq_st_t st;
		firing_event_select_seq_pkg::src_t arm_src;
		firing_event_select_seq_pkg::src_t fire_src;
		firing_event_select_seq_pkg::src_t smp_src;
		logic [CW-1:0] reading_count_cmd;
		logic [CW-1:0] rdg_cnt;
		logic arm_pend;
		logic fire_pend;
		logic [`TMR_W-1:0] tmr;
		logic hold;
		logic ext_prev;
		firing_event_select_seq_pkg::cmd_ent_t [QDEPTH-1:0] q;
		logic [PW-1:0] rd;
		logic [PW-1:0] wr;
		logic [QW-1:0] cnt;
		logic ready;
		logic err;
		logic start;
		logic done;
		logic armed;
		logic fired;
	} seq_state_t;

	seq_state_t s_q;
	seq_state_t s_d;
	logic ext_fall;
	logic syn_ok;
	logic exec;
	logic take;
	logic tmr_zero;
	firing_event_select_seq_pkg::cmd_ent_t head;

	function automatic logic [PW-1:0] ptr_next(input logic [PW-1:0] p);
		ptr_next = (p == PW'(QDEPTH - 1)) ? '0 : p + PW'(1);
	endfunction : ptr_next

	// which sources each level and measurement function allows
	function automatic logic src_ok(input logic [1:0] lvl, input firing_event_select_seq_pkg::src_t s,
			input firing_event_select_seq_pkg::func_t f);
		logic lvl_fn;
		logic tl_fn;
		lvl_fn = (f == firing_event_select_seq_pkg::FN_DCV) || (f == firing_event_select_seq_pkg::FN_DIG_DIRECT);
		tl_fn = !(f inside {firing_event_select_seq_pkg::FN_ACV_SYNC, firing_event_select_seq_pkg::FN_ACV_RNDM,
			firing_event_select_seq_pkg::FN_ACDCV_SYNC, firing_event_select_seq_pkg::FN_ACDCV_RNDM,
			firing_event_select_seq_pkg::FN_FREQ, firing_event_select_seq_pkg::FN_PER}); // see [RULE_16]
		case (s)
			firing_event_select_seq_pkg::SRC_AUTO, firing_event_select_seq_pkg::SRC_EXT, firing_event_select_seq_pkg::SRC_SYN: begin
				src_ok = 1'b1; // see [RULE_07] see [RULE_14]
			end
			firing_event_select_seq_pkg::SRC_HOLD, firing_event_select_seq_pkg::SRC_SGL: begin
				src_ok = (lvl != `LVL_SMP); // see [RULE_12] see [RULE_13]
			end
			firing_event_select_seq_pkg::SRC_LEVEL: begin
				src_ok = (lvl != `LVL_ARM) && lvl_fn; // see [RULE_09] see [RULE_10]
			end
			firing_event_select_seq_pkg::SRC_LINE: begin
				src_ok = (lvl != `LVL_ARM) && tl_fn; // see [RULE_11]
			end
			firing_event_select_seq_pkg::SRC_TIMER: begin
				src_ok = (lvl == `LVL_SMP) && tl_fn; // see [RULE_15]
			end
			default: begin
				src_ok = 1'b0;
			end
		endcase
	endfunction : src_ok

	// whether the selected source occurs this cycle
	function automatic logic ev_hit(input firing_event_select_seq_pkg::src_t s, input logic pend,
			input logic fall, input logic syn, input logic lvl, input logic line,
			input logic tz);
		case (s)
			firing_event_select_seq_pkg::SRC_AUTO: ev_hit = 1'b1; // see [RULE_07]
			firing_event_select_seq_pkg::SRC_EXT: ev_hit = fall; // see [RULE_08]
			firing_event_select_seq_pkg::SRC_LEVEL: ev_hit = lvl; // see [RULE_09]
			firing_event_select_seq_pkg::SRC_LINE: ev_hit = line; // see [RULE_11]
			firing_event_select_seq_pkg::SRC_SGL: ev_hit = pend; // see [RULE_12]
			firing_event_select_seq_pkg::SRC_SYN: ev_hit = syn; // see [RULE_14]
			firing_event_select_seq_pkg::SRC_TIMER: ev_hit = tz; // see [RULE_15]
			default: ev_hit = 1'b0; // see [RULE_13]
		endcase
	endfunction : ev_hit

	always_comb begin
		s_d = s_q;
		s_d.err = 1'b0;
		s_d.start = 1'b0;
		s_d.done = 1'b0;
		s_d.ext_prev = i_ext_firing_event_select_n;
		ext_fall = s_q.ext_prev & ~i_ext_firing_event_select_n; // see [RULE_08]
		syn_ok = i_outbuf_empty & i_mem_empty & i_host_req; // see [RULE_14]
		tmr_zero = (s_q.tmr == '0);
		head = s_q.q[s_q.rd];
		exec = (s_q.cnt != '0) && !s_q.hold;
		take = i_cmd_valid && s_q.ready;
		if (!tmr_zero) begin
			s_d.tmr = s_q.tmr - `TMR_W'(1);
		end

		// trigger hierarchy: arm, fire, then one reading per sample
		case (s_q.st)
			firing_event_select_seq_pkg::ST_ARM: begin
				if (ev_hit(s_q.arm_src, s_q.arm_pend, ext_fall, syn_ok, 1'b0, 1'b0,
						1'b0)) begin
					s_d.st = firing_event_select_seq_pkg::ST_FIRE; // see [RULE_03]
					if (s_q.arm_src == firing_event_select_seq_pkg::SRC_SGL) begin
						s_d.arm_src = firing_event_select_seq_pkg::SRC_HOLD; // see [RULE_12]
						s_d.arm_pend = 1'b0;
					end
				end
			end
			firing_event_select_seq_pkg::ST_FIRE: begin
				if (ev_hit(s_q.fire_src, s_q.fire_pend, ext_fall, syn_ok, i_level_hit,
						i_line_zero, 1'b0)) begin
					s_d.st = firing_event_select_seq_pkg::ST_SMP; // see [RULE_04]
					s_d.rdg_cnt = '0;
					s_d.tmr = '0;
					if (s_q.fire_src == firing_event_select_seq_pkg::SRC_SGL) begin
						s_d.fire_src = firing_event_select_seq_pkg::SRC_HOLD; // see [RULE_12]
						s_d.fire_pend = 1'b0;
					end
				end
			end
			firing_event_select_seq_pkg::ST_SMP: begin
				if (ev_hit(s_q.smp_src, 1'b0, ext_fall, syn_ok, i_level_hit, i_line_zero,
						tmr_zero)) begin
					s_d.start = 1'b1; // see [RULE_01] see [RULE_05]
					s_d.st = firing_event_select_seq_pkg::ST_READ;
					// interval runs from one reading start to the next
					s_d.tmr = i_timer_cycles; // see [RULE_15]
				end
			end
			default: begin
				if (i_reading_done) begin
					s_d.rdg_cnt = s_q.rdg_cnt + CW'(1); // see [RULE_05]
					if (s_q.rdg_cnt + CW'(1) >= s_q.reading_count_cmd) begin
						s_d.done = 1'b1;
						s_d.st = firing_event_select_seq_pkg::ST_ARM; // see [RULE_22]
						s_d.hold = 1'b0; // see [RULE_20]
					end else begin
						s_d.st = firing_event_select_seq_pkg::ST_SMP;
					end
				end
			end
		endcase

		// command execution comes after the sequencer so a new one-shot hold wins
		if (exec) begin
			s_d.rd = ptr_next(s_q.rd); // see [RULE_21]
			case (head.code)
				firing_event_select_seq_pkg::CMD_ARM_SRC: begin
					if (src_ok(`LVL_ARM, head.src, i_func)) begin
						s_d.arm_src = head.src; // see [RULE_19]
						s_d.arm_pend = (head.src == firing_event_select_seq_pkg::SRC_SGL);
						s_d.hold = s_d.arm_pend && !i_input_command_buffer_en; // see [RULE_20]
					end else begin
						s_d.err = 1'b1;
					end
				end
				firing_event_select_seq_pkg::CMD_FIRE_SRC: begin
					if (src_ok(`LVL_FIRE, head.src, i_func)) begin
						s_d.fire_src = head.src; // see [RULE_19]
						s_d.fire_pend = (head.src == firing_event_select_seq_pkg::SRC_SGL);
						s_d.hold = s_d.fire_pend && !i_input_command_buffer_en; // see [RULE_20]
					end else begin
						s_d.err = 1'b1;
					end
				end
				firing_event_select_seq_pkg::CMD_READ_COUNT: begin
					if (src_ok(`LVL_SMP, head.src, i_func) && head.count != '0) begin
						s_d.reading_count_cmd = head.count; // see [RULE_06]
						s_d.smp_src = head.src;
					end else begin
						s_d.err = 1'b1;
					end
				end
				default: begin
					// every default state aborts the group in progress, a start included
					s_d.st = firing_event_select_seq_pkg::ST_ARM;
					s_d.start = 1'b0;
					s_d.arm_pend = 1'b0;
					s_d.fire_pend = 1'b0;
					s_d.hold = 1'b0;
					s_d.reading_count_cmd = `RDG_CNT_RESET; // see [RULE_17]
					s_d.smp_src = firing_event_select_seq_pkg::SRC_AUTO;
					s_d.arm_src = firing_event_select_seq_pkg::SRC_AUTO;
					s_d.fire_src = firing_event_select_seq_pkg::SRC_AUTO;
					if (head.code == firing_event_select_seq_pkg::CMD_PRESET_STD) begin
						s_d.fire_src = firing_event_select_seq_pkg::SRC_SYN; // see [RULE_18]
					end else if (head.code == firing_event_select_seq_pkg::CMD_DIGITIZING_DEFAULT_STATE) begin
						s_d.arm_src = firing_event_select_seq_pkg::SRC_HOLD;
					end
				end
			endcase
		end

		if (take) begin
			s_d.q[s_q.wr] = '{code: i_cmd_code, src: i_cmd_src, count: i_cmd_count};
			s_d.wr = ptr_next(s_q.wr);
		end
		s_d.cnt = s_q.cnt + QW'(take) - QW'(exec);
		// buffer on: accept while room; off: one command at a time, none while held
		if (i_input_command_buffer_en) begin
			s_d.ready = (s_d.cnt < QW'(QDEPTH)); // see [RULE_21]
		end else begin
			s_d.ready = (s_d.cnt == '0) && !s_d.hold; // see [RULE_20]
		end
		s_d.armed = (s_d.st != firing_event_select_seq_pkg::ST_ARM);
		s_d.fired = (s_d.st == firing_event_select_seq_pkg::ST_SMP) || (s_d.st == firing_event_select_seq_pkg::ST_READ);
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_q <= '0; // all sources automatic at power-on, see [RULE_02]
			s_q.reading_count_cmd <= `RDG_CNT_RESET; // see [RULE_17]
			s_q.ext_prev <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_cmd_ready = s_q.ready;
	assign o_cmd_error = s_q.err;
	assign o_reading_start = s_q.start;
	assign o_armed = s_q.armed;
	assign o_fired = s_q.fired;
	assign o_group_done = s_q.done;
	assign o_arm_src = s_q.arm_src;
	assign o_fire_src = s_q.fire_src;
	assign o_smp_src = s_q.smp_src;
	assign o_rdg_count = s_q.rdg_cnt;

	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rst_n);

	sequence seq_last_done;
		s_q.st == firing_event_select_seq_pkg::ST_READ && i_reading_done && !exec
			&& s_q.rdg_cnt + CW'(1) >= s_q.reading_count_cmd;
	endsequence

	sequence seq_preset_std;
		exec && head.code == firing_event_select_seq_pkg::CMD_PRESET_STD;
	endsequence

	a_start_after_fire: assert property ( // see [RULE_01]
		o_reading_start |-> $past(s_q.st) == firing_event_select_seq_pkg::ST_SMP && o_fired
	) else $error("reading started outside sample level");

	a_auto_arm_passes: assert property ( // see [RULE_07]
		s_q.st == firing_event_select_seq_pkg::ST_ARM && s_q.arm_src == firing_event_select_seq_pkg::SRC_AUTO && !exec
			|=> s_q.st == firing_event_select_seq_pkg::ST_FIRE
	) else $error("automatic arming did not pass at once");

	a_hold_stays: assert property ( // see [RULE_13]
		s_q.st == firing_event_select_seq_pkg::ST_ARM && s_q.arm_src == firing_event_select_seq_pkg::SRC_HOLD && !exec
			|=> s_q.st == firing_event_select_seq_pkg::ST_ARM
	) else $error("suspended arming level moved");

	a_one_shot_hold: assert property ( // see [RULE_12]
		s_q.st == firing_event_select_seq_pkg::ST_FIRE && s_q.fire_src == firing_event_select_seq_pkg::SRC_SGL
			&& s_q.fire_pend && !exec
			|=> s_q.fire_src == firing_event_select_seq_pkg::SRC_HOLD && s_q.st == firing_event_select_seq_pkg::ST_SMP
	) else $error("one-shot firing did not revert to suspend");

	a_ext_falling: assert property ( // see [RULE_08]
		s_q.st == firing_event_select_seq_pkg::ST_ARM && s_q.arm_src == firing_event_select_seq_pkg::SRC_EXT && !exec
			&& !$fell(i_ext_firing_event_select_n) |=> s_q.st == firing_event_select_seq_pkg::ST_ARM
	) else $error("external arming without a falling edge");

	a_syn_gated: assert property ( // see [RULE_14]
		s_q.st == firing_event_select_seq_pkg::ST_FIRE && s_q.fire_src == firing_event_select_seq_pkg::SRC_SYN && !exec
			&& !(i_outbuf_empty && i_mem_empty && i_host_req)
			|=> s_q.st == firing_event_select_seq_pkg::ST_FIRE
	) else $error("host-pull firing without a data request");

	a_count_bound: assert property ( // see [RULE_05]
		s_q.fired |-> s_q.rdg_cnt < s_q.reading_count_cmd
	) else $error("reading count passed its limit");

	a_group_return: assert property ( // see [RULE_22]
		seq_last_done |=> o_group_done && s_q.st == firing_event_select_seq_pkg::ST_ARM
	) else $error("group end did not return to arming");

	a_preset_std: assert property ( // see [RULE_18]
		seq_preset_std |=> s_q.fire_src == firing_event_select_seq_pkg::SRC_SYN
			&& s_q.reading_count_cmd == `RDG_CNT_RESET && s_q.smp_src == firing_event_select_seq_pkg::SRC_AUTO
	) else $error("standard default state wrong");

	a_level_reject: assert property ( // see [RULE_10]
		exec && head.code == firing_event_select_seq_pkg::CMD_FIRE_SRC
			&& head.src == firing_event_select_seq_pkg::SRC_LEVEL
			&& !(i_func inside {firing_event_select_seq_pkg::FN_DCV, firing_event_select_seq_pkg::FN_DIG_DIRECT})
			|=> o_cmd_error && $stable(s_q.fire_src)
	) else $error("level source accepted for wrong function");

	a_bus_held: assert property ( // see [RULE_20]
		s_q.hold && !$past(i_input_command_buffer_en) |-> !o_cmd_ready
	) else $error("bus released during one-shot group");

endmodule : measurement_trigger_sequencer

// ### tb/front_end_model.sv
`timescale 1ns/1ns
module front_end_model #(
	parameter int DLY = 3
) (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	// requests from the bench and the sequencer
	input wire logic i_start,
	input wire logic i_fall_req,
	// answers
	output logic o_done,
	output logic o_ext_firing_event_select_n
);
	int busy_cnt;
	int low_cnt;
	// a reading takes DLY cycles, then done pulses for one cycle
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			busy_cnt <= 0;
			o_done <= 1'b0;
		end else begin
			o_done <= (busy_cnt == 1);
			if (i_start)
				busy_cnt <= DLY;
			else if (busy_cnt > 0)
				busy_cnt <= busy_cnt - 1;
		end
	end
	// trigger idles high; an event is a two-cycle low pulse so the edge is seen
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			low_cnt <= 0;
		else if (i_fall_req)
			low_cnt <= 2;
		else if (low_cnt > 0)
			low_cnt <= low_cnt - 1;
	end
	assign o_ext_firing_event_select_n = (low_cnt == 0);
endmodule : front_end_model

// ### tb/measurement_trigger_sequencer_bench.sv
`timescale 1ns/1ns
module measurement_trigger_sequencer_bench;
	logic i_ref_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_cmd_valid = 1'b0;
	firing_event_select_seq_pkg::cmd_t i_cmd_code = firing_event_select_seq_pkg::CMD_ARM_SRC;
	firing_event_select_seq_pkg::src_t i_cmd_src = firing_event_select_seq_pkg::SRC_AUTO;
	logic [15:0] i_cmd_count = 16'h0001;
	logic i_input_command_buffer_en = 1'b0;
	logic i_host_req = 1'b0;
	logic i_outbuf_empty = 1'b1;
	logic i_mem_empty = 1'b1;
	logic i_level_hit = 1'b0;
	logic i_line_zero = 1'b0;
	logic [31:0] i_timer_cycles = 32'h0000_000a;
	firing_event_select_seq_pkg::func_t i_func = firing_event_select_seq_pkg::FN_DCV;
	logic fall_req = 1'b0;
	logic ext_firing_event_select_n, reading_done, cmd_ready, cmd_error, reading_start, armed, fired, group_done;
	firing_event_select_seq_pkg::src_t arm_src, fire_src, smp_src;
	logic [15:0] rdg_count;
	int num_errors = 0;
	int tests_run = 0;
	int cyc = 0;
	int starts = 0;
	int last = 0;
	int min_gap = 999;
	logic err_seen = 1'b0;
	int i;
	firing_event_select_seq_pkg::cmd_t cc[6] = '{firing_event_select_seq_pkg::CMD_ARM_SRC, firing_event_select_seq_pkg::CMD_ARM_SRC,
		firing_event_select_seq_pkg::CMD_FIRE_SRC, firing_event_select_seq_pkg::CMD_FIRE_SRC,
		firing_event_select_seq_pkg::CMD_READ_COUNT, firing_event_select_seq_pkg::CMD_READ_COUNT};
	firing_event_select_seq_pkg::src_t ss[6] = '{firing_event_select_seq_pkg::SRC_LEVEL, firing_event_select_seq_pkg::SRC_LINE,
		firing_event_select_seq_pkg::SRC_TIMER, firing_event_select_seq_pkg::SRC_LEVEL, firing_event_select_seq_pkg::SRC_TIMER,
		firing_event_select_seq_pkg::SRC_AUTO};
	firing_event_select_seq_pkg::func_t fn[6] = '{firing_event_select_seq_pkg::FN_DCV, firing_event_select_seq_pkg::FN_DCV,
		firing_event_select_seq_pkg::FN_DCV, firing_event_select_seq_pkg::FN_FREQ, firing_event_select_seq_pkg::FN_ACV_SYNC,
		firing_event_select_seq_pkg::FN_DCV};
	logic [15:0] cn[6] = '{16'h0001, 16'h0001, 16'h0001, 16'h0001, 16'h0001, 16'h0000};

	measurement_trigger_sequencer u_dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
		.i_cmd_valid(i_cmd_valid), .i_cmd_code(i_cmd_code), .i_cmd_src(i_cmd_src),
		.i_cmd_count(i_cmd_count), .i_input_command_buffer_en(i_input_command_buffer_en), .i_host_req(i_host_req),
		.i_outbuf_empty(i_outbuf_empty), .i_mem_empty(i_mem_empty), .i_ext_firing_event_select_n(ext_firing_event_select_n),
		.i_level_hit(i_level_hit), .i_line_zero(i_line_zero), .i_timer_cycles(i_timer_cycles),
		.i_func(i_func), .i_reading_done(reading_done), .o_cmd_ready(cmd_ready),
		.o_cmd_error(cmd_error), .o_reading_start(reading_start), .o_armed(armed),
		.o_fired(fired), .o_group_done(group_done), .o_arm_src(arm_src),
		.o_fire_src(fire_src), .o_smp_src(smp_src), .o_rdg_count(rdg_count));
	front_end_model u_front (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_start(reading_start),
		.i_fall_req(fall_req), .o_done(reading_done), .o_ext_firing_event_select_n(ext_firing_event_select_n));

	initial begin
		forever #10 i_ref_clk = ~i_ref_clk;
	end

	task end_sim();
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_sim

	task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// hold the request until an edge with ready high, then release on that edge
	task cmd(input firing_event_select_seq_pkg::cmd_t c, input firing_event_select_seq_pkg::src_t s, input logic [15:0] n);
		int k;
		k = 0;
		@(posedge i_ref_clk);
		i_cmd_valid <= 1'b1;
		i_cmd_code <= c;
		i_cmd_src <= s;
		i_cmd_count <= n;
		@(negedge i_ref_clk);
		while (cmd_ready !== 1'b1 && k < 500) begin
			k++;
			@(negedge i_ref_clk);
		end
		@(posedge i_ref_clk);
		i_cmd_valid <= 1'b0;
		repeat (4) @(posedge i_ref_clk);
		@(negedge i_ref_clk);
	endtask : cmd

	task clr();
		@(negedge i_ref_clk);
		starts = 0;
		err_seen = 1'b0;
		min_gap = 999;
	endtask : clr

	task pulse(input int w);
		@(posedge i_ref_clk);
		case (w)
			0: i_line_zero <= 1'b1;
			1: fall_req <= 1'b1;
			default: i_host_req <= 1'b1;
		endcase
		@(posedge i_ref_clk);
		i_line_zero <= 1'b0;
		fall_req <= 1'b0;
		i_host_req <= 1'b0;
		repeat (10) @(negedge i_ref_clk);
	endtask : pulse

	task wait_done();
		int k;
		for (k = 0; k < 300 && group_done !== 1'b1; k++)
			@(negedge i_ref_clk);
		repeat (3) @(negedge i_ref_clk);
	endtask : wait_done

	// the timer gap is only meaningful between starts of one group
	always @(posedge i_ref_clk) begin
		cyc <= cyc + 1;
		if (cmd_error === 1'b1)
			err_seen <= 1'b1;
		if (reading_start === 1'b1) begin
			starts <= starts + 1;
			last <= cyc;
			if (starts > 0 && cyc - last < min_gap)
				min_gap <= cyc - last;
		end
		if (cyc == 20000) begin
			num_errors++;
			end_sim();
		end
	end

	initial begin
		repeat (6) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		repeat (2) @(negedge i_ref_clk);
		check("sources", 16'({arm_src, fire_src, smp_src}), 16'h0000);
		clr();
		repeat (30) @(negedge i_ref_clk);
		check("free run", 16'(starts > 0), 16'h0001);
		cmd(firing_event_select_seq_pkg::CMD_FIRE_SRC, firing_event_select_seq_pkg::SRC_HOLD, 16'h0001);
		repeat (20) @(negedge i_ref_clk);
		clr();
		repeat (30) @(negedge i_ref_clk);
		check("suspended", 16'(starts), 16'h0000);
		cmd(firing_event_select_seq_pkg::CMD_READ_COUNT, firing_event_select_seq_pkg::SRC_AUTO, 16'h0003);
		clr();
		cmd(firing_event_select_seq_pkg::CMD_FIRE_SRC, firing_event_select_seq_pkg::SRC_SGL, 16'h0001);
		check("ready held", 16'(cmd_ready), 16'h0000);
		wait_done();
		check("group", 16'(starts), 16'h0003);
		check("fire src", 16'(fire_src), 16'(firing_event_select_seq_pkg::SRC_HOLD));
		check("ready back", 16'(cmd_ready), 16'h0001);
		for (i = 0; i < 6; i++) begin
			@(posedge i_ref_clk);
			i_func <= fn[i];
			clr();
			cmd(cc[i], ss[i], cn[i]);
			check("refused", 16'(err_seen), 16'h0001);
		end
		check("arm kept", 16'(arm_src), 16'(firing_event_select_seq_pkg::SRC_AUTO));
		cmd(firing_event_select_seq_pkg::CMD_READ_COUNT, firing_event_select_seq_pkg::SRC_LINE, 16'h0002);
		cmd(firing_event_select_seq_pkg::CMD_FIRE_SRC, firing_event_select_seq_pkg::SRC_EXT, 16'h0001);
		clr();
		pulse(0);
		check("early sample", 16'(starts), 16'h0000);
		pulse(1);
		check("fired", 16'(fired), 16'h0001);
		pulse(0);
		pulse(0);
		check("line group", 16'(starts), 16'h0002);
		check("rdg count", rdg_count, 16'h0002);
		check("rearmed", 16'(armed), 16'h0001);
		cmd(firing_event_select_seq_pkg::CMD_READ_COUNT, firing_event_select_seq_pkg::SRC_TIMER, 16'h0003);
		clr();
		cmd(firing_event_select_seq_pkg::CMD_FIRE_SRC, firing_event_select_seq_pkg::SRC_SGL, 16'h0001);
		wait_done();
		check("timer group", 16'(starts), 16'h0003);
		check("timer gap", 16'(min_gap >= 11), 16'h0001);
		cmd(firing_event_select_seq_pkg::CMD_PRESET_STD, firing_event_select_seq_pkg::SRC_AUTO, 16'h0001);
		check("std", 16'({fire_src, smp_src}), 16'({firing_event_select_seq_pkg::SRC_SYN, 3'h0}));
		@(posedge i_ref_clk);
		i_outbuf_empty <= 1'b0;
		clr();
		pulse(2);
		check("pull blocked", 16'(starts), 16'h0000);
		@(posedge i_ref_clk);
		i_outbuf_empty <= 1'b1;
		pulse(2);
		check("pull", 16'(starts), 16'h0001);
		@(posedge i_ref_clk);
		i_input_command_buffer_en <= 1'b1;
		cmd(firing_event_select_seq_pkg::CMD_FIRE_SRC, firing_event_select_seq_pkg::SRC_HOLD, 16'h0001);
		cmd(firing_event_select_seq_pkg::CMD_FIRE_SRC, firing_event_select_seq_pkg::SRC_AUTO, 16'h0001);
		check("queued", 16'(fire_src), 16'(firing_event_select_seq_pkg::SRC_AUTO));
		clr();
		repeat (30) @(negedge i_ref_clk);
		check("resumed", 16'(starts > 0), 16'h0001);
		cmd(firing_event_select_seq_pkg::CMD_READ_COUNT, firing_event_select_seq_pkg::SRC_LINE, 16'h0005);
		cmd(firing_event_select_seq_pkg::CMD_RESET, firing_event_select_seq_pkg::SRC_AUTO, 16'h0001);
		check("reset srcs", 16'({arm_src, fire_src, smp_src}), 16'h0000);
		end_sim();
	end
endmodule : measurement_trigger_sequencer_bench
